// ### test/host_bit_reader.sv
/* host side reader on the link clock: one 40-bit buffer read per go.
   assumes: go is a level from the bench, answered by rd_done. */
`timescale 1ns/1ns
module host_bit_reader (
    // link clock
    input  wire logic        lk_clk,
    // bench handshake and result
    input  wire logic        go,
    output logic             rd_done,
    output logic [31:0]      rd_data,
    output logic [7:0]       rd_stat,
    // buffer read side
    output logic             lk_read_active,
    output logic             lk_shift,
    input  wire logic        lk_sdo_bit
);
    logic [39:0] bits_r;  // bits in arrival order
    // start, wait for bit 0, then shift 39 times with shift held high
    initial begin
        lk_read_active = 1'b0;
        lk_shift = 1'b0;
        rd_done = 1'b0;
        forever begin
            @(posedge lk_clk);
            if (go && !rd_done) begin
                lk_read_active <= 1'b1;
                repeat (2) @(posedge lk_clk);
                lk_shift <= 1'b1;
                for (int i = 0; i < 40; i++) begin
                    @(negedge lk_clk);
                    bits_r[i] = lk_sdo_bit;
                    if (i < 39) @(posedge lk_clk);
                    if (i == 38) lk_shift <= 1'b0;
                end
                @(posedge lk_clk);
                lk_read_active <= 1'b0;
                rd_data <= bits_r[31:0];
                rd_stat <= {bits_r[32], bits_r[33], bits_r[34], bits_r[35],
                            bits_r[36], bits_r[37], bits_r[38], bits_r[39]};
                rd_done <= 1'b1;
            end else if (!go) begin
                rd_done <= 1'b0;
            end
        end
    end
endmodule

// ### test/rx_bit_fifo_with_lock_properties.sv
/* timing checks on the receive buffer status outputs, clk_sys domain.
   assumes: bound to rx_bit_fifo_with_lock; receiver events are pulses. */
`timescale 1ns/1ns
module rx_bit_fifo_with_lock_properties (
    // clock and reset
    input wire logic                             clk_sys,
    input wire logic                             srst,
    // configuration levels
    input wire logic                             packet_buffer_mode,
    input wire logic                             lock_enable,
    input wire logic                             init_at_cycle_start,
    input wire logic                             receive_chain_init_select,
    input wire logic                             eom_return_to_polling,
    input wire logic                             rate_above_22k,
    // receiver events
    input wire logic                             frame_start_pattern,
    input wire logic                             rx_data_clk,
    input wire logic                             end_of_message,
    input wire logic                             sync_lost,
    input wire logic                             enter_slave_run,
    input wire logic                             poll_to_run,
    // status outputs
    input wire logic                             buffer_locked,
    input wire logic                             rx_chain_hold,
    input wire logic                             overflow,
    input wire logic                             writing,
    input wire logic [rx_fifo_pkg::LEN_LO_W-1:0] payload_length_low,
    input wire logic [rx_fifo_pkg::LEN_HI_W-1:0] length_msb_holder,
    input wire logic                             length_valid
);
    import rx_fifo_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // length is only trusted under this configuration
    wire trust_w = !receive_chain_init_select && (rate_above_22k || !eom_return_to_polling);
    // message end while a frame is open and lock is wanted
    sequence s_eom_lock;
        packet_buffer_mode && lock_enable && end_of_message && writing;
    endsequence
    // cycle start with init, no competing write or message end
    sequence s_cycle_init;
        packet_buffer_mode && init_at_cycle_start && (enter_slave_run || poll_to_run)
            && !rx_data_clk && !end_of_message;
    endsequence
    chk_lock_at_eom: assert property (s_eom_lock |=> buffer_locked && !writing)
        else $error("lock did not follow message end");
    chk_hold_tracks_lock: assert property (rx_chain_hold == buffer_locked)
        else $error("receiver hold differs from lock");
    chk_match_opens: assert property (packet_buffer_mode && frame_start_pattern
        && !buffer_locked && !end_of_message && !sync_lost |=> writing)
        else $error("pattern match did not open frame");
    chk_end_closes: assert property (packet_buffer_mode && (end_of_message || sync_lost)
        && !frame_start_pattern |=> !writing)
        else $error("frame stayed open after end");
    chk_locked_no_write: assert property (buffer_locked |-> !writing)
        else $error("frame open while locked");
    chk_unlock_on_clear: assert property (!lock_enable |=> !buffer_locked)
        else $error("lock held with lock disabled");
    chk_init_clears: assert property (s_cycle_init |=> !buffer_locked && !overflow
        && payload_length_low == '0 && length_msb_holder == '0)
        else $error("cycle start init incomplete");
    chk_mode_freezes: assert property (!packet_buffer_mode |=> !writing
        && $stable(overflow) && $stable(payload_length_low))
        else $error("buffer changed outside buffer mode");
    chk_length_trust: assert property (1'b1 |=> length_valid == $past(trust_w))
        else $error("length valid flag wrong");
    chk_overflow_clear: assert property (packet_buffer_mode && overflow
        && frame_start_pattern && !rx_data_clk |=> !overflow)
        else $error("overflow kept after pattern match");
endmodule
bind rx_bit_fifo_with_lock rx_bit_fifo_with_lock_properties u_chk (.*);

// ### test/rx_bit_fifo_with_lock_test.sv
/* self-checking bench: receiver events on clk_sys, buffer reads on lk_clk.
   assumes: package, design, checker and host reader compiled first. */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module rx_bit_fifo_with_lock_test;
    import rx_fifo_pkg::*;
    // event bit positions in ev_r
    localparam logic [5:0] MT = 6'h20, DC = 6'h10, EM = 6'h08, SL = 6'h04, SR = 6'h02, PR = 6'h01;
    logic clk_sys = 1'b0, lk_clk = 1'b0, srst = 1'b1, go = 1'b0;
    logic packet_buffer_mode = 1'b1, lock_enable = 1'b1, init_at_cycle_start = 1'b0;
    logic init_at_frame_start = 1'b0, ext_pattern_mode = 1'b0, receive_chain_init_select = 1'b0;
    logic eom_return_to_polling = 1'b1, rate_above_22k = 1'b1;
    logic [5:0] ev_r = 6'h00;  // receiver event pulses
    logic rx_data_bit = 1'b0, pattern_sel = 1'b0;
    logic frame_start_pattern, rx_data_clk, end_of_message, sync_lost;
    logic enter_slave_run, poll_to_run;
    logic buffer_locked, rx_chain_hold, overflow, writing, length_valid, rd_done;
    logic lk_read_active, lk_shift, lk_sdo_bit;
    logic [7:0] payload_length_low, rd_stat;
    logic [1:0] length_msb_holder;
    logic [31:0] rd_data;
    int n_errors = 0, tests_run = 0;
    assign {frame_start_pattern, rx_data_clk, end_of_message, sync_lost, enter_slave_run,
            poll_to_run} = ev_r;
    always #25 clk_sys = ~clk_sys;
    always begin
        #62 lk_clk = 1'b1;
        #63 lk_clk = 1'b0;
    end
    rx_bit_fifo_with_lock u_rx_bit_fifo_with_lock (.*);
    host_bit_reader u_host_bit_reader (.lk_clk(lk_clk), .go(go), .rd_done(rd_done),
        .rd_data(rd_data), .rd_stat(rd_stat), .lk_read_active(lk_read_active),
        .lk_shift(lk_shift), .lk_sdo_bit(lk_sdo_bit));
    // one-cycle event pulse, outputs settled on return
    task automatic fire(input logic [5:0] e, input logic b);
        @(posedge clk_sys);
        ev_r <= e;
        rx_data_bit <= b;
        pattern_sel <= b;
        @(posedge clk_sys);
        ev_r <= 6'h00;
        #1;
    endtask
    task automatic put_bits(input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) fire(DC, v[i]);
    endtask
    task automatic read_chk(input logic [31:0] d, input logic [5:0] n);
        @(posedge clk_sys);
        go <= 1'b1;
        for (int k = 0; k < 400 && !rd_done; k++) @(posedge clk_sys);
        `CHK("read done", 1'b1, rd_done)
        `CHK("read data", d, rd_data)
        `CHK("overflow bit", 1'b0, rd_stat[7])
        `CHK("bit count", n, rd_stat[5:0])
        go <= 1'b0;
        for (int k = 0; k < 40 && rd_done; k++) @(posedge clk_sys);
    endtask
    task automatic wait_unlock;
        for (int k = 0; k < 60 && buffer_locked; k++) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_trust;
        `CHK("length valid", 1'b1, length_valid)
        @(posedge clk_sys);
        receive_chain_init_select <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("length valid", 1'b0, length_valid)
        @(posedge clk_sys) receive_chain_init_select <= 1'b0;
    endtask
    task automatic t_lock_read;
        fire(MT, 1'b0);
        `CHK("writing", 1'b1, writing)
        put_bits(32'h0000000d, 5);
        fire(EM, 1'b0);
        `CHK("locked", 1'b1, buffer_locked)
        `CHK("hold", 1'b1, rx_chain_hold)
        `CHK("writing", 1'b0, writing)
        fire(MT, 1'b0);
        `CHK("writing", 1'b0, writing)
        `CHK("length low", 8'h05, payload_length_low)
        read_chk(32'h0000000d, 6'h05);
        wait_unlock();
        `CHK("locked", 1'b0, buffer_locked)
    endtask
    task automatic t_release;
        fire(MT, 1'b0);
        put_bits(32'h00000007, 3);
        fire(MT, 1'b0);
        `CHK("length low", 8'h03, payload_length_low)
        put_bits(32'h00000001, 1);
        fire(EM, 1'b0);
        @(posedge clk_sys);
        lock_enable <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("locked", 1'b0, buffer_locked)
        @(posedge clk_sys) lock_enable <= 1'b1;
        fire(MT, 1'b0);
        put_bits(32'h00000001, 1);
        fire(EM, 1'b0);
        @(posedge clk_sys);
        init_at_cycle_start <= 1'b1;
        fire(PR, 1'b0);
        `CHK("locked", 1'b0, buffer_locked)
        `CHK("length low", 8'h00, payload_length_low)
        fire(SR, 1'b0);
        @(posedge clk_sys) init_at_cycle_start <= 1'b0;
        read_chk(32'h00000000, 6'h00);
    endtask
    task automatic t_overflow;
        fire(MT, 1'b0);
        for (int i = 0; i < 257; i++) fire(DC, 1'b1);
        `CHK("overflow", 1'b1, overflow)
        fire(MT, 1'b0);
        `CHK("overflow", 1'b0, overflow)
        `CHK("length low", 8'h00, payload_length_low)
        fire(SL, 1'b0);
        `CHK("writing", 1'b0, writing)
    endtask
    task automatic t_ext_pattern;
        @(posedge clk_sys);
        ext_pattern_mode <= 1'b1;
        init_at_frame_start <= 1'b1;
        fire(MT, 1'b1);
        put_bits(32'h00000002, 2);
        fire(EM, 1'b0);
        read_chk(32'h00000005, 6'h03);
        wait_unlock();
        @(posedge clk_sys) ext_pattern_mode <= 1'b0;
    endtask
    task automatic t_mode_off;
        fire(MT, 1'b0);
        @(posedge clk_sys) packet_buffer_mode <= 1'b0;
        fire(DC, 1'b1);
        `CHK("writing", 1'b0, writing)
        fire(MT, 1'b0);
        `CHK("writing", 1'b0, writing)
        @(posedge clk_sys) packet_buffer_mode <= 1'b1;
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        t_trust();
        t_lock_read();
        t_release();
        t_overflow();
        t_ext_pattern();
        t_mode_off();
        report_and_stop();
    end
endmodule

// ### verilog/rx_bit_fifo_with_lock.sv
/*
 * bit-addressable receive buffer with end-of-message lock,
 * overflow flag, init triggers and last message length capture.
 * the write side runs on clk_sys next to the digital receiver; the
 * read side runs on lk_clk next to the serial slave controller.
 * assumes: receiver strobes are one-cycle pulses on clk_sys; the
 * read controller drives lk_read_active and lk_shift on lk_clk.
 */
`timescale 1ns/1ns
module rx_bit_fifo_with_lock (
    // system clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           srst,
    // configuration levels
    input  wire logic                           packet_buffer_mode,
    input  wire logic                           lock_enable,
    input  wire logic                           init_at_cycle_start,
    input  wire logic                           init_at_frame_start,
    input  wire logic                           ext_pattern_mode,
    input  wire logic                           receive_chain_init_select,
    input  wire logic                           eom_return_to_polling,
    input  wire logic                           rate_above_22k,
    // receiver events, one-cycle pulses
    input  wire logic                           frame_start_pattern,
    input  wire logic                           pattern_sel,
    input  wire logic                           rx_data_clk,
    input  wire logic                           rx_data_bit,
    input  wire logic                           end_of_message,
    input  wire logic                           sync_lost,
    input  wire logic                           enter_slave_run,
    input  wire logic                           poll_to_run,
    // status toward the receiver and registers
    output logic                                buffer_locked,
    output logic                                rx_chain_hold,
    output logic                                overflow,
    output logic                                writing,
    output logic [rx_fifo_pkg::LEN_LO_W-1:0]    payload_length_low,
    output logic [rx_fifo_pkg::LEN_HI_W-1:0]    length_msb_holder,
    output logic                                length_valid,
    // read side, link clock
    input  wire logic                           lk_clk,
    input  wire logic                           lk_read_active,
    input  wire logic                           lk_shift,
    output logic                                lk_sdo_bit
);
    import rx_fifo_pkg::*;

    // binary to gray
    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction

    // gray to binary
    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        gray2bin = b;
    endfunction

    // ---------------- write side, clk_sys ----------------
    logic [PW-1:0]    wr_ptr_r;      // write pointer with wrap bit
    logic [PW-1:0]    wr_ptr_nxt;    // next write pointer
    logic [PW-1:0]    wr_gray_r;     // gray copy sent to read side
    logic [PW-1:0]    rd_sync_g;     // read pointer seen here, gray
    logic [PW-1:0]    rd_sync_b;     // read pointer seen here, binary
    logic [PW-1:0]    occ;           // bits held
    logic [PW-1:0]    base;          // pointer after any init
    logic             locked_r;      // lock state
    logic             ovf_r;         // overflow flag
    logic             wr_on_r;       // frame in progress
    logic [LEN_W-1:0] len_cnt_r;     // running payload length
    logic [LEN_W-1:0] len_st_r;      // stored previous length
    logic             len_ok_r;      // length trust flag
    logic             fs;            // gated pattern match
    logic             cyc_ev;        // cycle start event
    logic             cyc_init;      // init at cycle start
    logic             fs_init;       // init at pattern match
    logic             buf_init;      // any init this cycle
    logic             accept;        // payload may enter
    logic             pre_wr;        // prefix bit write
    logic             dat_wr;        // payload bit write
    logic             wr_req;        // any write
    logic             wr_bit;        // bit being written
    logic             empty;         // everything read out
    logic             full;          // no free bit left
    logic [PW-1:0]    rd_gray_r;     // read pointer, gray, from read side
    logic [AW-1:0]    rd_addr;       // memory read address
    logic             mem_q;         // memory read data

    // read pointer arrives gray coded over two flops
    sync_2ff #(.W(PW)) u_rd_sync (
        .clk (clk_sys),
        .d   (rd_gray_r),
        .q   (rd_sync_g)
    );

    // event and write decoding
    always_comb begin
        rd_sync_b = gray2bin(rd_sync_g);
        occ       = wr_ptr_r - rd_sync_b;
        empty     = (occ == '0);
        full      = (occ == DEPTH);
        fs        = frame_start_pattern & packet_buffer_mode;
        cyc_ev    = enter_slave_run | poll_to_run;
        cyc_init  = packet_buffer_mode & init_at_cycle_start & cyc_ev;
        fs_init   = fs & (ovf_r | (init_at_frame_start & ~locked_r));
        buf_init  = cyc_init | fs_init;
        accept    = packet_buffer_mode & ~locked_r;
        pre_wr    = fs & accept & ext_pattern_mode;
        dat_wr    = rx_data_clk & wr_on_r & accept & ~fs;
        wr_req    = pre_wr | dat_wr;
        wr_bit    = pre_wr ? pattern_sel : rx_data_bit;
        // init empties the buffer by joining the read pointer
        base      = buf_init ? rd_sync_b : wr_ptr_r;
        wr_ptr_nxt = base + {{(PW-1){1'b0}}, wr_req};
    end

    // bit memory, written at the low address bits
    rx_bit_ram u_ram (
        .clk     (clk_sys),
        .wr_en   (wr_req),
        .wr_addr (base[AW-1:0]),
        .wr_bit  (wr_bit),
        .rd_addr (rd_addr),
        .rd_bit  (mem_q)
    );

    // write pointer and its gray copy
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr_r  <= '0;
            wr_gray_r <= '0;
        end else begin
            wr_ptr_r  <= wr_ptr_nxt;
            wr_gray_r <= bin2gray(wr_ptr_nxt);
        end
    end

    // frame in progress: opens at match, closes at end or sync loss
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_on_r <= 1'b0;
        end else if (~packet_buffer_mode || end_of_message || sync_lost) begin
            wr_on_r <= 1'b0;
        end else if (fs && accept) begin
            wr_on_r <= 1'b1;
        end
    end

    // lock: set at message end, dropped by lock or mode clear, empty buffer or cycle init
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            locked_r <= 1'b0;
        end else if (~lock_enable || ~packet_buffer_mode) begin
            locked_r <= 1'b0;
        end else if (end_of_message) begin
            locked_r <= 1'b1;
        end else if (locked_r && (empty || cyc_init)) begin
            locked_r <= 1'b0;
        end
    end

    // overflow: a write into a full buffer overtakes the reader
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ovf_r <= 1'b0;
        end else if (buf_init) begin
            ovf_r <= 1'b0;
        end else if (wr_req && full) begin
            ovf_r <= 1'b1;
        end
    end

    // running length, cleared at each match and each init
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            len_cnt_r <= '0;
        end else if (buf_init || fs) begin
            len_cnt_r <= '0;
        end else if (dat_wr && len_cnt_r != LEN_MAX) begin
            len_cnt_r <= len_cnt_r + 10'h001;
        end
    end

    // stored length: taken at the next match, cleared by init
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            len_st_r <= '0;
        end else if (buf_init) begin
            len_st_r <= '0;
        end else if (fs) begin
            len_st_r <= len_cnt_r;
        end
    end

    // trust flag for the stored length
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            len_ok_r <= 1'b0;
        end else begin
            len_ok_r <= ~receive_chain_init_select &
                        (rate_above_22k | ~eom_return_to_polling);
        end
    end

    // status outputs straight from flops
    assign buffer_locked      = locked_r;
    assign rx_chain_hold      = locked_r;
    assign overflow           = ovf_r;
    assign writing            = wr_on_r;
    assign payload_length_low = len_st_r[LEN_LO_W-1:0];
    assign length_msb_holder  = len_st_r[LEN_W-1:LEN_LO_W];
    assign length_valid       = len_ok_r;

    // ---------------- read side, lk_clk ----------------
    logic              lk_rst;       // reset seen on the link clock
    logic [PW-1:0]     wr_sync_g;    // write pointer seen here, gray
    logic [PW-1:0]     wr_sync_b;    // write pointer seen here, binary
    logic              ovf_lk;       // overflow seen here
    logic [PW-1:0]     rd_ptr_r;     // read pointer with wrap bit
    logic [PW-1:0]     avail;        // bits available to read
    logic [CNT_W-1:0]  cnt_nxt;      // valid count for a new read
    logic [CNT_W-1:0]  cnt_r;        // valid count of this read
    logic [IDX_W-1:0]  idx_r;        // bit position in the transfer
    logic [STAT_W-1:0] stat_sr_r;    // remaining status bits
    logic [STAT_W-1:0] status;       // status word of this read
    logic              act_d_r;      // read active, delayed
    logic              lk_start;     // read just began
    logic              step;         // a valid bit is consumed
    logic              sdo_r;        // serial data flop
    rd_state_e         rd_st_r;      // read sequencer state

    // reset, write pointer and overflow cross over two flops
    sync_2ff #(.W(1)) u_rst_sync (
        .clk (lk_clk),
        .d   (srst),
        .q   (lk_rst)
    );
    sync_2ff #(.W(PW)) u_wr_sync (
        .clk (lk_clk),
        .d   (wr_gray_r),
        .q   (wr_sync_g)
    );
    sync_2ff #(.W(1)) u_ovf_sync (
        .clk (lk_clk),
        .d   (ovf_r),
        .q   (ovf_lk)
    );

    // read side decoding
    always_comb begin
        wr_sync_b = gray2bin(wr_sync_g);
        avail     = wr_sync_b - rd_ptr_r;
        cnt_nxt   = (avail > {3'h0, DATA_BITS}) ? DATA_BITS : avail[CNT_W-1:0];
        lk_start  = lk_read_active & ~act_d_r;
        step      = (rd_st_r == RD_DATA) & lk_shift & ~lk_start & (idx_r < cnt_r);
        // look ahead one bit when the current one is consumed
        rd_addr   = step ? (rd_ptr_r[AW-1:0] + 8'h01) : rd_ptr_r[AW-1:0];
        status    = {ovf_lk, 1'b0, cnt_r};
    end

    // edge detector for the read request
    always_ff @(posedge lk_clk) begin
        if (lk_rst) begin
            act_d_r <= 1'b0;
        end else begin
            act_d_r <= lk_read_active;
        end
    end

    // read pointer steps once per valid bit shifted out
    always_ff @(posedge lk_clk) begin
        if (lk_rst) begin
            rd_ptr_r  <= '0;
            rd_gray_r <= '0;
        end else begin
            if (step) begin
                rd_ptr_r <= rd_ptr_r + 9'h001;
            end
            rd_gray_r <= bin2gray(rd_ptr_r);
        end
    end

    // read sequencer: 32 data bits then the status word
    always_ff @(posedge lk_clk) begin
        if (lk_rst) begin
            rd_st_r   <= RD_IDLE;
            idx_r     <= '0;
            cnt_r     <= '0;
            stat_sr_r <= '0;
            sdo_r     <= 1'b0;
        end else if (~lk_read_active) begin
            rd_st_r <= RD_IDLE;                                          // abandoned read
        end else if (lk_start) begin
            rd_st_r <= RD_DATA;
            idx_r   <= '0;
            cnt_r   <= cnt_nxt;
            sdo_r   <= (cnt_nxt != '0) ? mem_q : 1'b0;
        end else if (lk_shift) begin
            case (rd_st_r)
                RD_DATA: begin
                    idx_r <= idx_r + 6'h01;
                    if (idx_r == LAST_DATA) begin
                        rd_st_r   <= RD_STAT;
                        sdo_r     <= status[ST_OVF];
                        stat_sr_r <= {status[STAT_W-2:0], 1'b0};
                    end else begin
                        // first received bit goes out first
                        sdo_r <= ((idx_r + 6'h01) < cnt_r) ? mem_q : 1'b0;
                    end
                end
                RD_STAT: begin
                    idx_r     <= idx_r + 6'h01;
                    sdo_r     <= stat_sr_r[STAT_W-1];
                    stat_sr_r <= {stat_sr_r[STAT_W-2:0], 1'b0};
                    if (idx_r == LAST_IDX) begin
                        rd_st_r <= RD_IDLE;
                        sdo_r   <= 1'b0;
                    end
                end
                default: begin
                    rd_st_r <= RD_IDLE;                                  // extra shifts ignored
                end
            endcase
        end
    end

    assign lk_sdo_bit = sdo_r;
endmodule

// ### verilog/rx_bit_ram.sv
/*
 * 256 x 1 bit memory with a clocked write port and an
 * asynchronous read port usable from another clock domain.
 * assumes: the caller keeps read and write on different bits.
 */
`timescale 1ns/1ns
module rx_bit_ram (
    // write port, receiver clock
    input  wire logic                      clk,
    input  wire logic                      wr_en,
    input  wire logic [rx_fifo_pkg::AW-1:0] wr_addr,
    input  wire logic                      wr_bit,
    // read port, any domain
    input  wire logic [rx_fifo_pkg::AW-1:0] rd_addr,
    output logic                           rd_bit
);
    import rx_fifo_pkg::*;

    logic mem_r [0:255];   // one cell per received bit

    // store one bit per write strobe
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_bit;
        end
    end

    // independent read port
    assign rd_bit = mem_r[rd_addr];
endmodule

// ### verilog/rx_fifo_pkg.sv
/*
 * shared constants for the bit-addressable receive buffer:
 * sizes, pointer widths, length counter limits, read transfer layout.
 * assumes: included before every design file of the buffer.
 */
package rx_fifo_pkg;
    // buffer geometry
    localparam int unsigned AW        = 8;        // bit address width
    localparam int unsigned PW        = 9;        // pointer width, one wrap bit
    localparam logic [8:0]  DEPTH     = 9'h100;   // 256 bits
    // message length capture
    localparam int unsigned LEN_W     = 10;       // stored length width
    localparam logic [9:0]  LEN_MAX   = 10'h3ff;  // saturation value
    localparam int unsigned LEN_LO_W  = 8;        // low byte width
    localparam int unsigned LEN_HI_W  = 2;        // msb pair width
    // read transfer layout
    localparam int unsigned CNT_W     = 6;        // valid count field width
    localparam int unsigned IDX_W     = 6;        // bit index in transfer
    localparam logic [5:0]  DATA_BITS = 6'h20;    // 32 data bits per read
    localparam logic [5:0]  LAST_DATA = 6'h1f;    // index of last data bit
    localparam logic [5:0]  LAST_IDX  = 6'h27;    // index of last status bit
    localparam int unsigned STAT_W    = 8;        // status word width
    localparam int unsigned ST_OVF    = 7;        // overflow flag position
    localparam int unsigned ST_UNDEF  = 6;        // undefined position
    // read side state
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_DATA = 2'b01,
        RD_STAT = 2'b10
    } rd_state_e;
endpackage

// ### verilog/sync_2ff.sv
/*
 * two flip-flop synchroniser for levels and gray-coded words.
 * assumes: d is stable or changes one bit at a time between samples.
 */
`timescale 1ns/1ns
module sync_2ff #(
    parameter int unsigned W = 1
) (
    // destination clock
    input  wire logic         clk,
    // source level and synchronised copy
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;   // first stage, read only by q

    // two stages, no reset so the chain stays a pure delay
    always_ff @(posedge clk) begin
        meta_r <= d;
        q      <= meta_r;
    end
endmodule
